// ==== shared/fca_pkg.sv ====
// Constants, register map and state encoding of the frame acquisition control.
package fca_pkg;
	// Register byte offsets on the APB slave.
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_SEQ_LEN = 8'h04;
	localparam logic [7:0] OFS_BURST = 8'h08;
	localparam logic [7:0] OFS_SELECT = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_FRAMES = 8'h18;
	// Field widths.
	localparam int MODE_W = 2;
	localparam int LEN_W = 16;
	localparam int BURST_W = 8;
	localparam int SEL_W = 2;
	// Command register bit positions; each written one is a single pulse.
	localparam int CMD_PREPARE = 0;
	localparam int CMD_BEGIN = 1;
	localparam int CMD_END = 2;
	localparam int CMD_KILL = 3;
	localparam int CMD_CFG_BEGIN = 4;
	localparam int CMD_CFG_COMMIT = 5;
	localparam int CMD_FEAT_BEGIN = 6;
	localparam int CMD_FEAT_COMMIT = 7;
	localparam int CMD_CHECK = 8;
	// Status register bit positions.
	localparam int ST_ACTIVE = 0;
	localparam int ST_READBACK = 1;
	localparam int ST_CFG_OK = 2;
	localparam int ST_ARMED = 3;
	localparam int ST_BATCH = 4;
	localparam int ST_STOP = 5;
	// Capture modes.
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_ONE = 2'h1;
	localparam logic [1:0] MODE_SEQ = 2'h2;
	// Status selector codes.
	localparam logic [1:0] SEL_ACTIVE = 2'h0;
	localparam logic [1:0] SEL_WAIT = 2'h1;
	localparam logic [1:0] SEL_ARMED = 2'h2;
	localparam logic [1:0] SEL_STOP = 2'h3;
	// Reset values.
	localparam logic [1:0] RST_MODE = MODE_CONT;
	localparam logic [15:0] RST_SEQ_LEN = 16'h0001;
	localparam logic [7:0] RST_BURST = 8'h01;
	localparam logic [1:0] RST_SEL = SEL_ACTIVE;
	// Preparation latency of an arm, in ns, and in mclk cycles rounded up.
	localparam int ARM_NS = 40;
	localparam int CLK_NS = 10;
	localparam logic [3:0] ARM_CYC = 4'((ARM_NS + CLK_NS - 1) / CLK_NS);
	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_ARM = 4'h2,
		S_REQ = 4'h4,
		S_WAIT = 4'h8
	} fca_state_t;
endpackage : fca_pkg

// ==== verilog/fca_acq_ctrl.sv ====
// Frame acquisition sequencer with APB register slave and config checking.
//
// Summary of operation
// - Continuous mode captures frames until stopped.
// - One-shot mode captures one frame, then stops.
// - Counted mode captures programmed length, then stops.
// - Sequence length sets the frame count only in counted mode.
// - Stop lets the current frame finish.
// - Kill ends at once, cancels trigger wait.
// - Kill while idle changes nothing.
// - Prepare checks settings and readies capture.
// - First start auto-prepares; changes force re-prepare.
// - Selector picks signal shown by readback.
// - Active flag high whenever frames are being captured.
// - Burst length sets snapshots per frame.
// - Batch writes are not checked on arrival.
// - Batch commit checks, then applies configuration.
// - Feature batch behaves like register batch.
// - Check command validates configuration on demand, outside a batch.
// - Readable flag tells configuration is consistent.
`timescale 1ns/10ps
`default_nettype none
module fca_acq_ctrl (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sensor capture path, same clock domain.
	output logic snap_req,
	input wire logic snap_done,
	output logic frame_kill,
	output logic frame_done,
	// Status.
	output logic capture_in_progress,
	output logic cfg_ok_flag
);
	// A zero burst or an empty counted sequence can never complete.
	function automatic logic cfg_good(input logic [1:0] m,
			input logic [15:0] len, input logic [7:0] burst);
		logic mode_ok;
		mode_ok = (m == fca_pkg::MODE_CONT) || (m == fca_pkg::MODE_ONE) ||
			((m == fca_pkg::MODE_SEQ) && (len != 16'h0000));
		return mode_ok && (burst != 8'h00);
	endfunction : cfg_good

	// True when one more unit brings a count up to its limit.
	function automatic logic reached(input logic [15:0] cnt,
			input logic [15:0] lim);
		return ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
	endfunction : reached

	fca_pkg::fca_state_t st_q, st_d;
	logic [1:0] shd_mode_q, shd_mode_d, act_mode_q, act_mode_d;
	logic [15:0] shd_len_q, shd_len_d, act_len_q, act_len_d;
	logic [7:0] shd_burst_q, shd_burst_d, act_burst_q, act_burst_d;
	logic [1:0] sel_q, sel_d;
	logic cfg_ok_q, cfg_ok_d, armed_q, armed_d;
	logic batch_cfg_q, batch_cfg_d, batch_feat_q, batch_feat_d;
	logic [3:0] arm_cnt_q, arm_cnt_d;
	logic [7:0] snap_cnt_q, snap_cnt_d;
	logic [15:0] frame_cnt_q, frame_cnt_d;
	logic start_pend_q, start_pend_d, stop_pend_q, stop_pend_d;
	logic busy_q, busy_d, done_q, done_d, kill_q, kill_d;
	logic [31:0] rd_q, rd_d;
	logic addr_ok, apb_wr, cfg_wr, batch_open, shd_good, commit, arm_req;
	logic snap_last, frame_end, readback;
	logic [31:0] cmd;
	logic prepare_cmd, begin_capture_cmd, end_capture_cmd, kill_capture_cmd;
	logic batch_cfg_begin, batch_cfg_commit, batch_feat_begin;
	logic batch_feat_commit, cfg_check_cmd;

	// APB decode; the slave never waits, so every access is two cycles.
	assign addr_ok = paddr inside {fca_pkg::OFS_MODE, fca_pkg::OFS_SEQ_LEN,
		fca_pkg::OFS_BURST, fca_pkg::OFS_SELECT, fca_pkg::OFS_CMD,
		fca_pkg::OFS_STATUS, fca_pkg::OFS_FRAMES};
	assign apb_wr = psel && penable && pwrite && addr_ok;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = rd_q;
	assign cfg_wr = apb_wr && (paddr inside {fca_pkg::OFS_MODE,
		fca_pkg::OFS_SEQ_LEN, fca_pkg::OFS_BURST});

	// Command pulses live for the single cycle of the write access.
	assign cmd = (apb_wr && (paddr == fca_pkg::OFS_CMD)) ? pwdata : 32'h0000_0000;
	assign prepare_cmd = cmd[fca_pkg::CMD_PREPARE];
	assign begin_capture_cmd = cmd[fca_pkg::CMD_BEGIN];
	assign end_capture_cmd = cmd[fca_pkg::CMD_END];
	assign kill_capture_cmd = cmd[fca_pkg::CMD_KILL];
	assign batch_cfg_begin = cmd[fca_pkg::CMD_CFG_BEGIN];
	assign batch_cfg_commit = cmd[fca_pkg::CMD_CFG_COMMIT];
	assign batch_feat_begin = cmd[fca_pkg::CMD_FEAT_BEGIN];
	assign batch_feat_commit = cmd[fca_pkg::CMD_FEAT_COMMIT];
	assign cfg_check_cmd = cmd[fca_pkg::CMD_CHECK];

	// An arm is taken only from idle; kill in the same write wins.
	assign arm_req = (st_q == fca_pkg::S_IDLE) && !kill_capture_cmd &&
		(prepare_cmd || (begin_capture_cmd && !armed_q));

	// Configuration: software writes the shadow, checked sets reach active.
	always_comb begin
		shd_mode_d = shd_mode_q;
		shd_len_d = shd_len_q;
		shd_burst_d = shd_burst_q;
		sel_d = sel_q;
		if (apb_wr && (paddr == fca_pkg::OFS_MODE))
			shd_mode_d = pwdata[fca_pkg::MODE_W-1:0];
		if (apb_wr && (paddr == fca_pkg::OFS_SEQ_LEN))
			shd_len_d = pwdata[fca_pkg::LEN_W-1:0];
		if (apb_wr && (paddr == fca_pkg::OFS_BURST))
			shd_burst_d = pwdata[fca_pkg::BURST_W-1:0];
		if (apb_wr && (paddr == fca_pkg::OFS_SELECT))
			sel_d = pwdata[fca_pkg::SEL_W-1:0];
		batch_open = batch_cfg_q || batch_feat_q;
		shd_good = cfg_good(shd_mode_d, shd_len_d, shd_burst_d);
		commit = (batch_cfg_commit && batch_cfg_q) ||
			(batch_feat_commit && batch_feat_q);
		batch_cfg_d = (batch_cfg_q || batch_cfg_begin) && !batch_cfg_commit;
		batch_feat_d = (batch_feat_q || batch_feat_begin) && !batch_feat_commit;
		cfg_ok_d = cfg_ok_q;
		// Inside a batch plain writes skip the check entirely.
		if (commit || arm_req || (cfg_check_cmd && !batch_open) ||
				(cfg_wr && !batch_open))
			cfg_ok_d = shd_good;
		act_mode_d = act_mode_q;
		act_len_d = act_len_q;
		act_burst_d = act_burst_q;
		if (shd_good && (commit || arm_req || (cfg_wr && !batch_open))) begin
			act_mode_d = shd_mode_d;
			act_len_d = shd_len_d;
			act_burst_d = shd_burst_d;
		end
		// Any change of the applied set makes the next start re-arm.
		armed_d = armed_q;
		if ((act_mode_d != act_mode_q) || (act_len_d != act_len_q) ||
				(act_burst_d != act_burst_q))
			armed_d = 1'b0;
		if (arm_req && shd_good)
			armed_d = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			shd_mode_q <= fca_pkg::RST_MODE;
			shd_len_q <= fca_pkg::RST_SEQ_LEN;
			shd_burst_q <= fca_pkg::RST_BURST;
			act_mode_q <= fca_pkg::RST_MODE;
			act_len_q <= fca_pkg::RST_SEQ_LEN;
			act_burst_q <= fca_pkg::RST_BURST;
			sel_q <= fca_pkg::RST_SEL;
			cfg_ok_q <= 1'b1;
			armed_q <= 1'b0;
			batch_cfg_q <= 1'b0;
			batch_feat_q <= 1'b0;
		end else begin
			shd_mode_q <= shd_mode_d;
			shd_len_q <= shd_len_d;
			shd_burst_q <= shd_burst_d;
			act_mode_q <= act_mode_d;
			act_len_q <= act_len_d;
			act_burst_q <= act_burst_d;
			sel_q <= sel_d;
			cfg_ok_q <= cfg_ok_d;
			armed_q <= armed_d;
			batch_cfg_q <= batch_cfg_d;
			batch_feat_q <= batch_feat_d;
		end
	end

	// A frame is the last snapshot of a burst coming back.
	assign snap_last = reached({8'h00, snap_cnt_q}, {8'h00, act_burst_q});
	assign frame_end = (st_q == fca_pkg::S_WAIT) && snap_done && snap_last;

	// Sequencer: arm, request snapshots, count frames, stop or abort.
	always_comb begin
		st_d = st_q;
		arm_cnt_d = arm_cnt_q;
		snap_cnt_d = snap_cnt_q;
		frame_cnt_d = frame_cnt_q;
		start_pend_d = start_pend_q;
		stop_pend_d = stop_pend_q;
		done_d = 1'b0;
		kill_d = 1'b0;
		if (kill_capture_cmd && (st_q != fca_pkg::S_IDLE)) begin
			st_d = fca_pkg::S_IDLE;
			kill_d = 1'b1;
		end else begin
			unique case (st_q)
				fca_pkg::S_IDLE: begin
					// Kill here falls through with no effect.
					snap_cnt_d = 8'h00;
					frame_cnt_d = 16'h0000;
					stop_pend_d = 1'b0;
					start_pend_d = begin_capture_cmd;
					if (arm_req && shd_good) begin
						st_d = fca_pkg::S_ARM;
						arm_cnt_d = fca_pkg::ARM_CYC;
					end else if (begin_capture_cmd && armed_q && !kill_capture_cmd) begin
						st_d = fca_pkg::S_REQ;
					end
				end
				fca_pkg::S_ARM: begin
					if (begin_capture_cmd)
						start_pend_d = 1'b1;
					if (end_capture_cmd) begin
						st_d = fca_pkg::S_IDLE;
					end else if (arm_cnt_q == 4'h1) begin
						st_d = start_pend_d ? fca_pkg::S_REQ : fca_pkg::S_IDLE;
					end else begin
						arm_cnt_d = arm_cnt_q - 4'h1;
					end
				end
				fca_pkg::S_REQ: begin
					st_d = fca_pkg::S_WAIT;
					if (end_capture_cmd)
						stop_pend_d = 1'b1;
				end
				fca_pkg::S_WAIT: begin
					if (end_capture_cmd)
						stop_pend_d = 1'b1;
					if (snap_done && !snap_last) begin
						snap_cnt_d = snap_cnt_q + 8'h01;
						st_d = fca_pkg::S_REQ;
					end else if (frame_end) begin
						snap_cnt_d = 8'h00;
						frame_cnt_d = frame_cnt_q + 16'h0001;
						done_d = 1'b1;
						// Stop only on a frame boundary; continuous runs on.
						if (stop_pend_d || (act_mode_q == fca_pkg::MODE_ONE) ||
								((act_mode_q == fca_pkg::MODE_SEQ) &&
								reached(frame_cnt_q, act_len_q)))
							st_d = fca_pkg::S_IDLE;
						else
							st_d = fca_pkg::S_REQ;
					end
				end
				default: st_d = fca_pkg::S_IDLE;
			endcase
		end
		busy_d = (st_d == fca_pkg::S_REQ) || (st_d == fca_pkg::S_WAIT) ||
			((st_d == fca_pkg::S_ARM) && start_pend_d);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= fca_pkg::S_IDLE;
			arm_cnt_q <= 4'h0;
			snap_cnt_q <= 8'h00;
			frame_cnt_q <= 16'h0000;
			start_pend_q <= 1'b0;
			stop_pend_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			kill_q <= 1'b0;
		end else begin
			st_q <= st_d;
			arm_cnt_q <= arm_cnt_d;
			snap_cnt_q <= snap_cnt_d;
			frame_cnt_q <= frame_cnt_d;
			start_pend_q <= start_pend_d;
			stop_pend_q <= stop_pend_d;
			busy_q <= busy_d;
			done_q <= done_d;
			kill_q <= kill_d;
		end
	end

	assign snap_req = (st_q == fca_pkg::S_REQ);
	assign frame_kill = kill_q;
	assign frame_done = done_q;
	assign capture_in_progress = busy_q;
	assign cfg_ok_flag = cfg_ok_q;

	// Status readback mux over the internal acquisition signals.
	always_comb begin
		unique case (sel_q)
			fca_pkg::SEL_ACTIVE: readback = busy_q;
			fca_pkg::SEL_WAIT: readback = (st_q == fca_pkg::S_WAIT);
			fca_pkg::SEL_ARMED: readback = armed_q;
			fca_pkg::SEL_STOP: readback = stop_pend_q;
		endcase
	end

	// Read data is captured in the setup phase so it comes from a flop.
	always_comb begin
		rd_d = rd_q;
		if (psel && !penable && !pwrite) begin
			rd_d = 32'h0000_0000;
			unique case (paddr)
				fca_pkg::OFS_MODE: rd_d[fca_pkg::MODE_W-1:0] = shd_mode_q;
				fca_pkg::OFS_SEQ_LEN: rd_d[fca_pkg::LEN_W-1:0] = shd_len_q;
				fca_pkg::OFS_BURST: rd_d[fca_pkg::BURST_W-1:0] = shd_burst_q;
				fca_pkg::OFS_SELECT: rd_d[fca_pkg::SEL_W-1:0] = sel_q;
				fca_pkg::OFS_STATUS: begin
					rd_d[fca_pkg::ST_ACTIVE] = busy_q;
					rd_d[fca_pkg::ST_READBACK] = readback;
					rd_d[fca_pkg::ST_CFG_OK] = cfg_ok_q;
					rd_d[fca_pkg::ST_ARMED] = armed_q;
					rd_d[fca_pkg::ST_BATCH] = batch_cfg_q || batch_feat_q;
					rd_d[fca_pkg::ST_STOP] = stop_pend_q;
				end
				fca_pkg::OFS_FRAMES: rd_d[fca_pkg::LEN_W-1:0] = frame_cnt_q;
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst)
			rd_q <= 32'h0000_0000;
		else
			rd_q <= rd_d;
	end

	// Checks on sequencing and configuration handling.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_frame_end;
		frame_end && !kill_capture_cmd;
	endsequence

	sequence s_gone_idle;
		(st_q == fca_pkg::S_IDLE) && !capture_in_progress;
	endsequence

	property p_cont_runs;
		s_frame_end ##0 (act_mode_q == fca_pkg::MODE_CONT) && !stop_pend_q &&
			!end_capture_cmd |=> (st_q == fca_pkg::S_REQ) && capture_in_progress;
	endproperty
	a_cont_runs: assert property (p_cont_runs) else $error("continuous run stopped");

	property p_one_stops;
		s_frame_end ##0 (act_mode_q == fca_pkg::MODE_ONE) |=> s_gone_idle;
	endproperty
	a_one_stops: assert property (p_one_stops) else $error("one-shot kept running");

	property p_seq_len;
		s_frame_end ##0 (act_mode_q == fca_pkg::MODE_SEQ) && !stop_pend_q &&
			!end_capture_cmd |=> ((st_q == fca_pkg::S_IDLE) ==
			reached($past(frame_cnt_q), $past(act_len_q))) && frame_done;
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("counted length wrong");

	property p_stop_finishes;
		(st_q == fca_pkg::S_WAIT) && end_capture_cmd && !kill_capture_cmd &&
			!snap_done |=> (st_q == fca_pkg::S_WAIT) && stop_pend_q && !frame_kill;
	endproperty
	a_stop_finishes: assert property (p_stop_finishes) else $error("stop cut frame");

	property p_kill;
		kill_capture_cmd && (st_q != fca_pkg::S_IDLE) |=> s_gone_idle ##0
			frame_kill ##1 !frame_kill;
	endproperty
	a_kill: assert property (p_kill) else $error("kill did not end capture");

	property p_kill_idle;
		kill_capture_cmd && (st_q == fca_pkg::S_IDLE) |=>
			(st_q == fca_pkg::S_IDLE) && !frame_kill && $stable(armed_q);
	endproperty
	a_kill_idle: assert property (p_kill_idle) else $error("idle kill had effect");

	property p_auto_arm;
		(st_q == fca_pkg::S_IDLE) && begin_capture_cmd && !armed_q &&
			!kill_capture_cmd && shd_good |=> (st_q == fca_pkg::S_ARM) && armed_q &&
			capture_in_progress;
	endproperty
	a_auto_arm: assert property (p_auto_arm) else $error("first start not armed");

	property p_skip_arm;
		(st_q == fca_pkg::S_IDLE) && begin_capture_cmd && armed_q &&
			!prepare_cmd && !kill_capture_cmd |=> (st_q == fca_pkg::S_REQ) ##1
			((st_q == fca_pkg::S_WAIT) || (st_q == fca_pkg::S_IDLE));
	endproperty
	a_skip_arm: assert property (p_skip_arm) else $error("armed start re-armed");

	property p_batch_hold;
		batch_open && cfg_wr |=> $stable(act_mode_q) && $stable(act_len_q) &&
			$stable(act_burst_q) && $stable(cfg_ok_flag);
	endproperty
	a_batch_hold: assert property (p_batch_hold) else $error("batch write applied");

	property p_commit;
		commit |=> (cfg_ok_flag == $past(shd_good)) &&
			(!cfg_ok_flag || (act_len_q == shd_len_q));
	endproperty
	a_commit: assert property (p_commit) else $error("commit check wrong");

	property p_readback;
		(sel_q == fca_pkg::SEL_ACTIVE) && (st_q == fca_pkg::S_WAIT) |-> readback;
	endproperty
	a_readback: assert property (p_readback) else $error("readback not active");
endmodule : fca_acq_ctrl
`default_nettype wire

// ==== tb/fca_cap_model.sv ====
// Behavioural model of the sensor capture path behind the sequencer.
`timescale 1ns/10ps
`default_nettype none
module fca_cap_model (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Capture handshake with the sequencer.
	input wire logic snap_req,
	input wire logic frame_kill,
	output logic snap_done,
	// Snapshot duration in cycles, one or more.
	input wire logic [7:0] delay
);
	logic [7:0] cnt_q;

	// A kill drops the snapshot in flight, so no stray done can follow it.
	always_ff @(posedge mclk) begin
		snap_done <= 1'b0;
		if (srst || frame_kill) begin
			cnt_q <= 8'h00;
		end else if (snap_req) begin
			cnt_q <= delay;
		end else if (cnt_q == 8'h01) begin
			snap_done <= 1'b1;
			cnt_q <= 8'h00;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule : fca_cap_model
`default_nettype wire

// ==== tb/test_frame_acquisition_control.sv ====
// Self-checking bench for the frame acquisition control.
`timescale 1ns/10ps
`default_nettype none
module test_frame_acquisition_control;
	logic mclk, srst, psel, penable, pwrite, pready, pslverr, err_val;
	logic [7:0] paddr, delay;
	logic [31:0] pwdata, prdata, rd_val, st;
	logic snap_req, snap_done, frame_kill, frame_done, got_req;
	logic capture_in_progress, cfg_ok_flag;
	int failures = 0, n_tests = 0, cyc = 0, wr_cyc = 0, req_lat = 0;
	int frames = 0, snaps = 0, kills = 0, f0, s0, k0;

	fca_acq_ctrl dut_u (.mclk(mclk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.snap_req(snap_req), .snap_done(snap_done), .frame_kill(frame_kill),
		.frame_done(frame_done), .capture_in_progress(capture_in_progress),
		.cfg_ok_flag(cfg_ok_flag));
	fca_cap_model cap_u (.mclk(mclk), .srst(srst), .snap_req(snap_req),
		.frame_kill(frame_kill), .snap_done(snap_done), .delay(delay));

	// Free-running 100 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Event counters only grow, so scenarios compare differences.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (frame_done === 1'b1) frames <= frames + 1;
		if (snap_req === 1'b1) snaps <= snaps + 1;
		if (frame_kill === 1'b1) kills <= kills + 1;
		if (snap_req === 1'b1 && !got_req) begin
			got_req <= 1'b1;
			req_lat <= cyc - wr_cyc;
		end
		if (cyc > 20000) begin
			failures = failures + 1;
			close_out();
		end
	end

	// Compares one value and counts it.
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd_val = prdata;
		err_val = pslverr;
		wr_cyc = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] mask,
		input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, rd_val & mask, exp);
	endtask : rdchk

	task automatic cmd(input int b);
		wr(fca_pkg::OFS_CMD, 32'h1 << b);
	endtask : cmd

	// Start a run and rearm the latency probe.
	task automatic go();
		got_req <= 1'b0;
		cmd(fca_pkg::CMD_BEGIN);
	endtask : go

	// Bounded wait for the run to end; two edges let the counters settle.
	task automatic wait_idle();
		for (int i = 0; i < 2000 && capture_in_progress !== 1'b0; i++)
			@(posedge mclk);
		chk("idle after run", 32'(capture_in_progress), 32'h0);
		repeat (2) @(posedge mclk);
	endtask : wait_idle

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	// Main sequence of scenarios.
	initial begin
		srst <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		got_req <= 1'b0;
		delay <= 8'h03;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		// Reset values, write-only command word and an unmapped address.
		rdchk(fca_pkg::OFS_MODE, 32'hFFFFFFFF, 32'h0, "mode reset");
		rdchk(fca_pkg::OFS_SEQ_LEN, 32'hFFFFFFFF, 32'h1, "length reset");
		rdchk(fca_pkg::OFS_BURST, 32'hFFFFFFFF, 32'h1, "burst reset");
		rdchk(fca_pkg::OFS_SELECT, 32'hFFFFFFFF, 32'h0, "select reset");
		rdchk(fca_pkg::OFS_STATUS, 32'hFFFFFFFF, 32'h4, "status reset");
		rdchk(fca_pkg::OFS_CMD, 32'hFFFFFFFF, 32'h0, "command read");
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped read", rd_val, 32'h0);
		chk("unmapped error", 32'(err_val), 32'h1);
		chk("ready", 32'(pready), 32'h1);
		rdchk(fca_pkg::OFS_FRAMES, 32'hFFFFFFFF, 32'h0, "frames reset");
		// One-shot ignores the length and arms itself on the first start.
		wr(fca_pkg::OFS_SEQ_LEN, 32'h3);
		wr(fca_pkg::OFS_MODE, 32'h1);
		f0 = frames;
		go();
		wait_idle();
		chk("one-shot frames", 32'(frames - f0), 32'h1);
		chk("auto arm delay", 32'(req_lat), 32'(fca_pkg::ARM_CYC) + 1);
		f0 = frames;
		go();
		wait_idle();
		chk("one-shot ignores length", 32'(frames - f0), 32'h1);
		chk("rearm skipped", 32'(req_lat), 32'h1);
		// Counted sequence with two snapshots per frame.
		wr(fca_pkg::OFS_BURST, 32'h2);
		wr(fca_pkg::OFS_MODE, 32'h2);
		f0 = frames;
		s0 = snaps;
		go();
		wait_idle();
		chk("counted frames", 32'(frames - f0), 32'h3);
		chk("burst snapshots", 32'(snaps - s0), 32'h6);
		// Continuous capture runs until stop, which completes the frame.
		wr(fca_pkg::OFS_MODE, 32'h0);
		f0 = frames;
		s0 = snaps;
		k0 = kills;
		go();
		for (int i = 0; i < 2000 && frames < f0 + 3; i++) @(posedge mclk);
		apb(1'b0, fca_pkg::OFS_FRAMES, 32'h0);
		chk("frame count read", 32'(rd_val[15:0] >= 16'h0003), 32'h1);
		rdchk(fca_pkg::OFS_STATUS, 32'h1, 32'h1, "active in run");
		cmd(fca_pkg::CMD_END);
		wait_idle();
		chk("continuous frames", 32'(frames - f0 >= 4), 32'h1);
		chk("whole frames", 32'(snaps - s0), 32'(2 * (frames - f0)));
		chk("stop kills", 32'(kills - k0), 32'h0);
		// Kill while a slow snapshot is outstanding and a stop is pending.
		delay <= 8'h28;
		go();
		repeat (3) @(posedge mclk);
		wr(fca_pkg::OFS_SELECT, 32'(fca_pkg::SEL_WAIT));
		rdchk(fca_pkg::OFS_STATUS, 32'h2, 32'h2, "wait readback");
		cmd(fca_pkg::CMD_END);
		wr(fca_pkg::OFS_SELECT, 32'(fca_pkg::SEL_STOP));
		rdchk(fca_pkg::OFS_STATUS, 32'h22, 32'h22, "stop readback");
		f0 = frames;
		cmd(fca_pkg::CMD_KILL);
		repeat (2) @(posedge mclk);
		chk("kill pulse", 32'(kills - k0), 32'h1);
		chk("kill ends run", 32'(capture_in_progress), 32'h0);
		chk("kill discards frame", 32'(frames - f0), 32'h0);
		// A kill while idle must leave the state alone.
		apb(1'b0, fca_pkg::OFS_STATUS, 32'h0);
		st = rd_val;
		cmd(fca_pkg::CMD_KILL);
		repeat (2) @(posedge mclk);
		chk("idle kill pulse", 32'(kills - k0), 32'h1);
		rdchk(fca_pkg::OFS_STATUS, 32'hFFFFFFFF, st, "idle kill");
		delay <= 8'h03;
		// Back in idle, the next start is accepted.
		wr(fca_pkg::OFS_MODE, 32'h1);
		f0 = frames;
		go();
		wait_idle();
		chk("start after kill", 32'(frames - f0), 32'h1);
		// A changed length drops the arm; a prepare restores it before the start.
		wr(fca_pkg::OFS_SEQ_LEN, 32'h4);
		rdchk(fca_pkg::OFS_STATUS, 32'h8, 32'h0, "armed cleared");
		cmd(fca_pkg::CMD_PREPARE);
		repeat (8) @(posedge mclk);
		wr(fca_pkg::OFS_SELECT, 32'(fca_pkg::SEL_ARMED));
		rdchk(fca_pkg::OFS_STATUS, 32'hE, 32'hE, "armed readback");
		go();
		wait_idle();
		chk("armed start delay", 32'(req_lat), 32'h1);
		wr(fca_pkg::OFS_BURST, 32'h1);
		rdchk(fca_pkg::OFS_STATUS, 32'h8, 32'h0, "armed after change");
		// The reserved mode code is an inconsistent set.
		wr(fca_pkg::OFS_MODE, 32'h3);
		chk("illegal mode", 32'(cfg_ok_flag), 32'h0);
		wr(fca_pkg::OFS_MODE, 32'h1);
		// Register batch: no check on arrival, check at commit.
		cmd(fca_pkg::CMD_CFG_BEGIN);
		wr(fca_pkg::OFS_BURST, 32'h0);
		chk("ok in batch", 32'(cfg_ok_flag), 32'h1);
		cmd(fca_pkg::CMD_CFG_COMMIT);
		chk("ok after commit", 32'(cfg_ok_flag), 32'h0);
		go();
		repeat (10) @(posedge mclk);
		chk("bad config start", 32'(capture_in_progress), 32'h0);
		wr(fca_pkg::OFS_BURST, 32'h1);
		chk("ok after repair", 32'(cfg_ok_flag), 32'h1);
		// Feature batch behaves the same way; then explicit checks.
		cmd(fca_pkg::CMD_FEAT_BEGIN);
		wr(fca_pkg::OFS_MODE, 32'h2);
		wr(fca_pkg::OFS_SEQ_LEN, 32'h0);
		chk("ok in feature batch", 32'(cfg_ok_flag), 32'h1);
		cmd(fca_pkg::CMD_FEAT_COMMIT);
		chk("ok after feature commit", 32'(cfg_ok_flag), 32'h0);
		cmd(fca_pkg::CMD_CHECK);
		chk("check on bad set", 32'(cfg_ok_flag), 32'h0);
		wr(fca_pkg::OFS_SEQ_LEN, 32'h2);
		cmd(fca_pkg::CMD_CHECK);
		rdchk(fca_pkg::OFS_STATUS, 32'h4, 32'h4, "ok flag read");
		f0 = frames;
		go();
		wait_idle();
		chk("applied after check", 32'(frames - f0), 32'h2);
		close_out();
	end
endmodule : test_frame_acquisition_control
`default_nettype wire
